/* File: dv/isa_exec_checker.sv */
// Port-level property checker for the move, shift and return executor
`timescale 1ns/1ps
`default_nettype none
`include "isa_exec_map.svh"
module isa_exec_checker #(
  parameter int DATA_W = `DATA_W,
  parameter int PC_W   = `PC_W
) (
  input wire logic                 ref_clk_in,
  input wire logic                 rst_in,
  input wire logic                 op_valid_in,
  input var  isa_exec_pkg::op_type op_in,
  input wire logic [6:0]           file_addr_in,
  input wire logic [7:0]           literal_in,
  input wire logic [DATA_W-1:0]    file_rdata_in,
  input wire logic [6:0]           file_addr_out,
  input wire logic                 file_we_out,
  input wire logic [DATA_W-1:0]    accumulator_out,
  input wire logic [DATA_W-1:0]    status_out,
  input wire logic [`BANK_W-1:0]   bank_select_reg_out,
  input wire logic [`PAGE_W-1:0]   pc_upper_latch_out,
  input wire logic [DATA_W-1:0]    prescaler_cfg_out,
  input wire logic [DATA_W-1:0]    irq_control_reg_out,
  input wire logic                 pc_load_en_out,
  input wire logic                 busy_out,
  input wire logic                 device_reset_out
);
  import isa_exec_pkg::*;
  // ==========================================================
  // Take qualifier and captured address
  logic       take;
  logic [6:0] cap_r;
  assign take = op_valid_in && !busy_out;
  always_ff @(posedge ref_clk_in) begin
    if (take) begin
      cap_r <= file_addr_in;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // ==========================================================
  // Properties; ports lag the internal state by one edge
  a_acc_lit_load: assert property (
    take && op_in == OP_ACC_LIT |->
    ##2 accumulator_out == $past(literal_in, 2)) else $error("acc literal");
  a_flags_left_alone: assert property (
    take && op_in inside {OP_ACC_LIT, OP_BANK_LIT, OP_PAGE_LIT, OP_ACC_STORE,
    OP_PRESCALE, OP_IND_STORE} |-> ##2 $stable(status_out))
    else $error("flags changed");
  a_bank_load: assert property (
    take && op_in == OP_BANK_LIT |-> ##2 bank_select_reg_out ==
    {1'b0, $past(literal_in[3:0], 2)}) else $error("bank literal");
  a_page_load: assert property (
    take && op_in == OP_PAGE_LIT |-> ##2 pc_upper_latch_out ==
    $past(literal_in[6:0], 2)) else $error("page literal");
  a_prescale_copy: assert property (
    take && op_in == OP_PRESCALE |-> ##2 prescaler_cfg_out ==
    $past(accumulator_out, 1)) else $error("prescaler copy");
  a_incr_result: assert property (
    take && op_in == OP_INCREMENT_FILE_OP && file_addr_in > 7'h01 |-> ##2
    status_out[`ZERO_BIT] == ($past(file_rdata_in, 2) == 8'hff))
    else $error("increment zero flag");
  a_shift_left_carry: assert property (
    take && op_in == OP_SHL && file_addr_in > 7'h01 |-> ##2
    status_out[`CARRY_BIT] == $past(file_rdata_in[7], 2))
    else $error("shift carry");
  a_rotate_only_carry: assert property (
    take && op_in == OP_ROT_LEFT && file_addr_in > 7'h01 |-> ##2
    status_out[`CARRY_BIT] == $past(file_rdata_in[7], 2) &&
    status_out[`ZERO_BIT] == $past(status_out[`ZERO_BIT], 1))
    else $error("rotate flags");
  a_store_write: assert property (
    take && op_in == OP_ACC_STORE && file_addr_in > 7'h01 |->
    ##[1:2] (file_we_out && file_addr_out == cap_r)) else $error("store");
  a_return_pops: assert property (
    take && op_in inside {OP_SUB_EXIT, OP_IRQ_EXIT, OP_LIT_EXIT} |->
    ##[1:2] pc_load_en_out) else $error("return without pc load");
  a_return_two_cycles: assert property (
    take && op_in inside {OP_SUB_EXIT, OP_IRQ_EXIT, OP_LIT_EXIT} |->
    ##1 busy_out ##1 !busy_out) else $error("return length");
  a_irq_enable_set: assert property (
    take && op_in == OP_IRQ_EXIT |-> ##[2:3] irq_control_reg_out[`GIE_BIT])
    else $error("global enable not set");
  a_soft_reset: assert property (
    take && op_in == OP_SW_RESET |-> ##[1:3] device_reset_out)
    else $error("software reset missing");
  c_sub_exit: cover property (take && op_in == OP_SUB_EXIT);
  c_ind_store: cover property (take && op_in == OP_IND_STORE);
  c_soft_reset: cover property (take && op_in == OP_SW_RESET);
endmodule
bind isa_move_shift_return_exec isa_exec_checker #(
  .DATA_W(DATA_W), .PC_W(PC_W)) u_isa_exec_checker (.*);
`default_nettype wire

/* File: dv/isa_move_shift_return_exec_tb.sv */
// Self-checking testbench for the move, shift and return executor
`timescale 1ns/1ps
`default_nettype none
module isa_move_shift_return_exec_tb;
  import isa_exec_pkg::*;
  logic        ref_clk_in, rst_in, op_valid_in, dest_in, ptr_sel_in;
  logic        rel_offset_in, file_we_out, mem_we_out, pc_load_en_out;
  logic        busy_out, device_reset_out;
  op_type      op_in;
  logic [1:0]  pointer_update_code_in;
  logic [5:0]  offset_in;
  logic [6:0]  file_addr_in, file_addr_out, pc_upper_latch_out, fw_a;
  logic [4:0]  bank_select_reg_out;
  logic [7:0]  literal_in, file_rdata_in, mem_rdata_in, file_wdata_out;
  logic [7:0]  mem_wdata_out, accumulator_out, status_out, fw_d, mw_d;
  logic [7:0]  prescaler_cfg_out, irq_control_reg_out, power_control_reg_out;
  logic [14:0] call_target_in, pc_in, pc_load_out, pl_v;
  logic [15:0] mem_addr_out, indirect_pointer0_out, indirect_pointer1_out;
  logic [15:0] mw_a;
  logic [7:0]  fmem [0:127];
  int          fails, checks, cyc, fw_n, mw_n, pl_n, dr_n, i;
  // Pointer walk from zero crosses both ends of the range
  localparam logic [1:0]  codes_tab [5] = '{2'b01, 2'b00, 2'b10, 2'b11, 2'b11};
  localparam logic [15:0] addr_tab [5] = '{16'hffff, 16'h0000, 16'h0000,
                                           16'h0001, 16'h0000};
  localparam logic [15:0] ptr_tab [5] = '{16'hffff, 16'h0000, 16'h0001,
                                          16'h0000, 16'hffff};
  assign file_rdata_in = fmem[file_addr_in];
  isa_move_shift_return_exec u_isa_move_shift_return_exec (.*);
  always #2.5 ref_clk_in = ~ref_clk_in;
  // ==========================================================
  // File model, pulse capture and hang guard
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (file_we_out === 1'b1) begin
      fmem[file_addr_out] <= file_wdata_out;
      fw_n <= fw_n + 1;
      fw_a <= file_addr_out;
      fw_d <= file_wdata_out;
    end
    if (mem_we_out === 1'b1) begin
      mw_n <= mw_n + 1;
      mw_a <= mem_addr_out;
      mw_d <= mem_wdata_out;
    end
    if (pc_load_en_out === 1'b1) begin
      pl_n <= pl_n + 1;
      pl_v <= pc_load_out;
    end
    if (device_reset_out === 1'b1) begin
      dr_n <= dr_n + 1;
    end
    if (cyc == 3000) begin
      fails++;
      stop_test();
    end
  end
  // ==========================================================
  // Access tasks
  task automatic issue(input op_type o, input logic [6:0] a,
                       input logic d, input logic [7:0] k);
    op_valid_in = 1'b1;
    op_in = o;
    file_addr_in = a;
    dest_in = d;
    literal_in = k;
    @(negedge ref_clk_in);
  endtask
  // Idle after every op: returns refuse the cycle after their take
  task automatic go(input op_type o, input logic [6:0] a,
                    input logic d, input logic [7:0] k);
    fw_n = 0;
    mw_n = 0;
    pl_n = 0;
    dr_n = 0;
    issue(o, a, d, k);
    op_valid_in = 1'b0;
    repeat (5) @(negedge ref_clk_in);
  endtask
  task automatic chk(input string name, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {ref_clk_in, op_valid_in, dest_in, ptr_sel_in, rel_offset_in} = '0;
    {fails, checks, cyc, fw_n, mw_n, pl_n, dr_n} = '0;
    rst_in = 1'b1;
    op_in = OP_NONE;
    {file_addr_in, literal_in, pointer_update_code_in, offset_in} = '0;
    {call_target_in, pc_in, mem_rdata_in} = '0;
    for (i = 0; i < 128; i++) fmem[i] = 8'h00;
    repeat (12) @(negedge ref_clk_in);
    rst_in = 1'b0;
    @(negedge ref_clk_in);
    chk("reset flag", 16'(power_control_reg_out[2]), 16'h0001);
    go(OP_ACC_LIT, 7'h00, 1'b0, 8'h00);
    chk("status", 16'(status_out), 16'h0000);
    go(OP_ACC_LIT, 7'h00, 1'b0, 8'h5a);
    chk("acc", 16'(accumulator_out), 16'h005a);
    fmem[7'h20] = 8'hff;
    go(OP_INCREMENT_FILE_OP, 7'h20, 1'b1, 8'h00);
    chk("inc write", 16'({fw_n[0], fw_a, fw_d}), 16'ha000);
    chk("inc status", 16'({accumulator_out, status_out}), 16'h5a04);
    go(OP_INCREMENT_FILE_OP, 7'h20, 1'b0, 8'h00);
    chk("inc acc", 16'({fw_n[0], accumulator_out}), 16'h0001);
    fmem[7'h21] = 8'h84;
    go(OP_IOR, 7'h21, 1'b0, 8'h00);
    chk("or", 16'({accumulator_out, status_out}), 16'h8500);
    fmem[7'h22] = 8'h81;
    go(OP_SHL, 7'h22, 1'b1, 8'h00);
    chk("shift left", 16'({fw_d, status_out}), 16'h0201);
    fmem[7'h23] = 8'h01;
    go(OP_SHR, 7'h23, 1'b0, 8'h00);
    chk("shift right", 16'({accumulator_out, status_out}), 16'h0005);
    fmem[7'h24] = 8'h66;
    go(OP_ROT_LEFT, 7'h24, 1'b0, 8'h00);
    chk("rotate left", 16'({accumulator_out, status_out}), 16'hcd04);
    fmem[7'h25] = 8'h03;
    go(OP_ROT_RIGHT, 7'h25, 1'b1, 8'h00);
    chk("rotate right", 16'({fw_d, status_out}), 16'h0105);
    fmem[7'h26] = 8'h7e;
    go(OP_COPY, 7'h26, 1'b0, 8'h00);
    chk("copy", 16'({accumulator_out, status_out}), 16'h7e01);
    go(OP_COPY, 7'h20, 1'b1, 8'h00);
    chk("copy test", 16'({fw_d, status_out}), 16'h0005);
    // Back to back: the store must see the literal just loaded
    fw_n = 0;
    issue(OP_ACC_LIT, 7'h00, 1'b0, 8'h3c);
    issue(OP_ACC_STORE, 7'h27, 1'b0, 8'h00);
    op_valid_in = 1'b0;
    repeat (5) @(negedge ref_clk_in);
    chk("store", 16'({1'b0, fw_a, fw_d}), 16'h273c);
    chk("store status", 16'(status_out), 16'h0005);
    go(OP_BANK_LIT, 7'h00, 1'b0, 8'h0f);
    go(OP_PAGE_LIT, 7'h00, 1'b0, 8'h7f);
    chk("bank", 16'(bank_select_reg_out), 16'h000f);
    chk("page", 16'(pc_upper_latch_out), 16'h007f);
    go(OP_PRESCALE, 7'h00, 1'b0, 8'h00);
    chk("prescaler", 16'(prescaler_cfg_out), 16'h003c);
    for (i = 0; i < 5; i++) begin
      pointer_update_code_in = codes_tab[i];
      go(OP_IND_STORE, 7'h00, 1'b0, 8'h00);
      chk("ind address", mw_a, addr_tab[i]);
      chk("pointer 0", indirect_pointer0_out, ptr_tab[i]);
      chk("ind status", 16'({mw_d, status_out}), 16'h3c05);
    end
    ptr_sel_in = 1'b1;
    rel_offset_in = 1'b1;
    offset_in = 6'h20;
    go(OP_IND_STORE, 7'h00, 1'b0, 8'h00);
    chk("offset low", mw_a, 16'hffe0);
    offset_in = 6'h1f;
    go(OP_IND_STORE, 7'h00, 1'b0, 8'h00);
    chk("offset high", mw_a, 16'h001f);
    chk("pointer 1", indirect_pointer1_out, 16'h0000);
    {ptr_sel_in, rel_offset_in} = 2'b00;
    pointer_update_code_in = 2'b10;
    mem_rdata_in = 8'h81;
    go(OP_IND_LOAD, 7'h00, 1'b0, 8'h00);
    chk("load", 16'({accumulator_out, status_out}), 16'h8101);
    chk("load pointer", indirect_pointer0_out, 16'h0000);
    pointer_update_code_in = 2'b01;
    mem_rdata_in = 8'h00;
    go(OP_IND_LOAD, 7'h00, 1'b0, 8'h00);
    chk("load zero", 16'({accumulator_out, status_out}), 16'h0005);
    go(OP_ACC_LIT, 7'h00, 1'b0, 8'ha5);
    go(OP_ACC_STORE, 7'h00, 1'b0, 8'h00);
    chk("alias address", mw_a, 16'hffff);
    chk("alias data", 16'({fw_n[0], mw_d}), 16'h00a5);
    pc_in = 15'h1234;
    go(OP_CALL, 7'h00, 1'b0, 8'h00);
    go(OP_SUB_EXIT, 7'h00, 1'b0, 8'h00);
    chk("return pc", 16'({pl_n[0], pl_v}), 16'h9235);
    chk("return status", 16'(status_out), 16'h0005);
    pc_in = 15'h2000;
    go(OP_CALL, 7'h00, 1'b0, 8'h00);
    go(OP_IRQ_EXIT, 7'h00, 1'b0, 8'h00);
    chk("irq return", 16'({irq_control_reg_out[7], pl_v}), 16'ha001);
    pc_in = 15'h0abc;
    go(OP_CALL, 7'h00, 1'b0, 8'h00);
    go(OP_LIT_EXIT, 7'h00, 1'b0, 8'h99);
    chk("literal return", 16'(pl_v), 16'h0abd);
    chk("literal acc", 16'(accumulator_out), 16'h0099);
    go(OP_SW_RESET, 7'h00, 1'b0, 8'h00);
    repeat (4) @(negedge ref_clk_in);
    chk("reset pulse", 16'(dr_n), 16'h0002);
    chk("reset state", 16'({power_control_reg_out[2], accumulator_out}),
        16'h0000);
    stop_test();
  end
endmodule
`default_nettype wire

/* File: hw/isa_exec_map.svh */
// Constant map for the move, shift and return execution block
`ifndef ISA_EXEC_MAP_SVH
`define ISA_EXEC_MAP_SVH
`define DATA_W        8
`define PTR_W         16
`define BANK_W        5
`define PAGE_W        7
`define PC_W          15
`define STACK_DEPTH   16
`define CARRY_BIT     0
`define ZERO_BIT      2
`define GIE_BIT       7
`define ALIAS0_ADDR   7'h00
`define ALIAS1_ADDR   7'h01
`define PTR_RESET     16'h0000
`define PC_RESET      15'h0000
`define RESET_HOLD    2
`endif

/* File: hw/isa_exec_pkg.sv */
// Types shared by the execution block, its checker and its testbench
package isa_exec_pkg;
  typedef enum logic [4:0] {
    OP_NONE        = 5'h00,
    OP_INCREMENT_FILE_OP        = 5'h01,
    OP_IOR         = 5'h02,
    OP_SHL         = 5'h03,
    OP_SHR         = 5'h04,
    OP_COPY        = 5'h05,
    OP_IND_LOAD    = 5'h06,
    OP_IND_STORE   = 5'h07,
    OP_BANK_LIT    = 5'h08,
    OP_PAGE_LIT    = 5'h09,
    OP_ACC_LIT     = 5'h0a,
    OP_ACC_STORE   = 5'h0b,
    OP_PRESCALE    = 5'h0c,
    OP_SW_RESET    = 5'h0d,
    OP_IRQ_EXIT    = 5'h0e,
    OP_SUB_EXIT    = 5'h0f,
    OP_LIT_EXIT    = 5'h10,
    OP_ROT_LEFT    = 5'h11,
    OP_ROT_RIGHT   = 5'h12,
    OP_CALL        = 5'h13
  } op_type;

  typedef enum logic [2:0] {
    ST_EXEC  = 3'b001,
    ST_POP   = 3'b010,
    ST_RESET = 3'b100
  } state_type;
endpackage

/* File: hw/isa_move_shift_return_exec.sv */
// Executor for move, shift, indirect and return instructions
`timescale 1ns/1ps
`default_nettype none
`include "isa_exec_map.svh"
// How it works
// - Destination bit 0 writes accumulator, 1 writes the file register.
// - Increment adds one to the file, updates only zero.
// - OR combines accumulator and file, updates only zero.
// - Left shift: bit 7 to carry, zero into bit 0, carry and zero.
// - Right shift: bit 0 to carry, zero into bit 7, carry and zero.
// - Copy moves file to destination and sets zero, one cycle.
// - Pointer code 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// - Offset form uses pointer plus signed offset, pointer unchanged.
// - The sixteen-bit pointer wraps at both ends.
// - Pointer updates touch no flag; indirect load still sets zero.
// - Alias register accesses go to the address in its pointer.
// - Bank literal loads the bank select register, no flags.
// - Page literal loads seven bits into the upper pc latch.
// - Accumulator literal loads eight bits, no flags.
// - Accumulator store copies accumulator to file, one cycle, no flags.
// - Prescaler load copies accumulator to prescaler configuration.
// - Software reset resets the device and clears its reset flag.
// - Interrupt exit pops pc and sets global enable, two cycles.
// - Subroutine exit pops stack into pc, two cycles, no flags.
// - Literal exit loads accumulator and pops pc, two cycles.
// - Rotate left through carry, one cycle, only carry changes.
// - Rotate right through carry, only carry changes.
module isa_move_shift_return_exec #(
  parameter int DATA_W = `DATA_W,
  parameter int PTR_W  = `PTR_W,
  parameter int PC_W   = `PC_W,
  parameter int DEPTH  = `STACK_DEPTH
) (
  input  wire logic                 ref_clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 op_valid_in,
  input  var  isa_exec_pkg::op_type op_in,
  input  wire logic [6:0]           file_addr_in,
  input  wire logic                 dest_in,
  input  wire logic [7:0]           literal_in,
  input  wire logic                 ptr_sel_in,
  input  wire logic [1:0]           pointer_update_code_in,
  input  wire logic                 rel_offset_in,
  input  wire logic [5:0]           offset_in,
  input  wire logic [PC_W-1:0]      call_target_in,
  input  wire logic [PC_W-1:0]      pc_in,
  input  wire logic [DATA_W-1:0]    file_rdata_in,
  input  wire logic [DATA_W-1:0]    mem_rdata_in,
  output logic [6:0]                file_addr_out,
  output logic                      file_we_out,
  output logic [DATA_W-1:0]         file_wdata_out,
  output logic [PTR_W-1:0]          mem_addr_out,
  output logic                      mem_we_out,
  output logic [DATA_W-1:0]         mem_wdata_out,
  output logic [DATA_W-1:0]         accumulator_out,
  output logic [DATA_W-1:0]         status_out,
  output logic [`BANK_W-1:0]        bank_select_reg_out,
  output logic [`PAGE_W-1:0]        pc_upper_latch_out,
  output logic [DATA_W-1:0]         prescaler_cfg_out,
  output logic [DATA_W-1:0]         irq_control_reg_out,
  output logic [DATA_W-1:0]         power_control_reg_out,
  output logic [PTR_W-1:0]          indirect_pointer0_out,
  output logic [PTR_W-1:0]          indirect_pointer1_out,
  output logic [PC_W-1:0]           pc_load_out,
  output logic                      pc_load_en_out,
  output logic                      busy_out,
  output logic                      device_reset_out
);
  import isa_exec_pkg::*;

  initial begin
    if (DATA_W != 8) $error("DATA_W must be 8");
    if (PTR_W != 16) $error("PTR_W must be 16");
  end

  // ==========================================================
  // State
  // ==========================================================
  state_type            state_r;
  state_type            state_nxt;
  logic [DATA_W-1:0]    acc_r;
  logic                 carry_r;
  logic                 zero_r;
  logic [PTR_W-1:0]     ptr_r [2];
  logic [1:0]           rst_cnt_r;
  logic                 ri_flag_r;
  logic                 pop_gie_r;
  logic                 pop_lit_r;
  logic [DATA_W-1:0]    pop_acc_r;

  stack_if #(.PC_W(PC_W)) stk ();

  return_stack #(.DEPTH(DEPTH), .PC_W(PC_W)) u_stack (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .stk        (stk)
  );

  // ==========================================================
  // Operand and result datapath
  // ==========================================================
  logic                 exec;
  logic                 alias_hit;
  logic                 alias_sel;
  logic [PTR_W-1:0]     sel_ptr;
  logic [PTR_W-1:0]     ptr_inc;
  logic [PTR_W-1:0]     ptr_dec;
  logic [PTR_W-1:0]     ptr_upd;
  logic [PTR_W-1:0]     ind_addr;
  logic [DATA_W-1:0]    src;
  logic [DATA_W-1:0]    result;
  logic                 res_carry;
  logic                 wr_carry;
  logic                 wr_zero;
  logic                 to_dest;

  assign exec      = op_valid_in && (state_r == ST_EXEC);
  assign alias_hit = (file_addr_in == `ALIAS0_ADDR) ||
                     (file_addr_in == `ALIAS1_ADDR);
  assign alias_sel = (file_addr_in == `ALIAS1_ADDR);
  assign sel_ptr   = ptr_r[ptr_sel_in];
  assign ptr_inc   = sel_ptr + PTR_W'(1);
  assign ptr_dec   = sel_ptr - PTR_W'(1);
  assign ptr_upd   = pointer_update_code_in[0] ? ptr_dec : ptr_inc;

  // Pre modes use the updated value, post modes the old one
  always_comb begin
    if (rel_offset_in) begin
      ind_addr = sel_ptr + {{(PTR_W-6){offset_in[5]}}, offset_in};
    end else if (!pointer_update_code_in[1]) begin
      ind_addr = ptr_upd;
    end else begin
      ind_addr = sel_ptr;
    end
  end

  // Alias reads come back over the indirect memory port
  assign src = alias_hit ? mem_rdata_in : file_rdata_in;

  always_comb begin
    result    = src;
    res_carry = carry_r;
    wr_carry  = 1'b0;
    wr_zero   = 1'b0;
    to_dest   = 1'b0;
    unique case (op_in)
      OP_INCREMENT_FILE_OP: begin
        result  = src + 8'h01;
        wr_zero = 1'b1;
        to_dest = 1'b1;
      end
      OP_IOR: begin
        result  = acc_r | src;
        wr_zero = 1'b1;
        to_dest = 1'b1;
      end
      OP_SHL: begin
        result    = {src[6:0], 1'b0};
        res_carry = src[7];
        wr_carry  = 1'b1;
        wr_zero   = 1'b1;
        to_dest   = 1'b1;
      end
      OP_SHR: begin
        result    = {1'b0, src[7:1]};
        res_carry = src[0];
        wr_carry  = 1'b1;
        wr_zero   = 1'b1;
        to_dest   = 1'b1;
      end
      OP_COPY: begin
        result  = src;
        wr_zero = 1'b1;
        to_dest = 1'b1;
      end
      OP_ROT_LEFT: begin
        result    = {src[6:0], carry_r};
        res_carry = src[7];
        wr_carry  = 1'b1;
        to_dest   = 1'b1;
      end
      OP_ROT_RIGHT: begin
        result    = {carry_r, src[7:1]};
        res_carry = src[0];
        wr_carry  = 1'b1;
        to_dest   = 1'b1;
      end
      OP_IND_LOAD: begin
        result  = mem_rdata_in;
        wr_zero = 1'b1;
      end
      default: begin
        result = src;
      end
    endcase
  end

  // ==========================================================
  // Sequencer
  // ==========================================================
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_EXEC: begin
        if (exec && op_in == OP_SW_RESET) begin
          state_nxt = ST_RESET;
        end else if (exec && (op_in == OP_IRQ_EXIT ||
                              op_in == OP_SUB_EXIT ||
                              op_in == OP_LIT_EXIT)) begin
          state_nxt = ST_POP;
        end
      end
      ST_POP: begin
        state_nxt = ST_EXEC;
      end
      ST_RESET: begin
        if (rst_cnt_r == 2'(`RESET_HOLD - 1)) begin
          state_nxt = ST_EXEC;
        end
      end
      default: begin
        state_nxt = ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_r <= ST_EXEC;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Reset pulse is held a few cycles so the whole core sees it
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || state_r != ST_RESET) begin
      rst_cnt_r <= 2'h0;
    end else begin
      rst_cnt_r <= rst_cnt_r + 2'h1;
    end
  end

  // Stack pops in the first cycle; pc loads at the end of the first
  assign stk.pop       = exec && (op_in == OP_IRQ_EXIT ||
                                  op_in == OP_SUB_EXIT ||
                                  op_in == OP_LIT_EXIT);
  assign stk.push      = exec && (op_in == OP_CALL);
  assign stk.push_data = pc_in + PC_W'(1);

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pc_load_out    <= `PC_RESET;
      pc_load_en_out <= 1'b0;
    end else begin
      pc_load_en_out <= stk.pop || (exec && op_in == OP_CALL);
      pc_load_out    <= stk.pop ? stk.top : call_target_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pop_gie_r <= 1'b0;
      pop_lit_r <= 1'b0;
      pop_acc_r <= 8'h00;
    end else begin
      pop_gie_r <= exec && op_in == OP_IRQ_EXIT;
      pop_lit_r <= exec && op_in == OP_LIT_EXIT;
      pop_acc_r <= literal_in;
    end
  end

  // ==========================================================
  // Architectural registers
  // ==========================================================
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || state_r == ST_RESET) begin
      acc_r <= 8'h00;
    end else if (pop_lit_r && state_r == ST_POP) begin
      acc_r <= pop_acc_r;
    end else if (exec && (op_in == OP_ACC_LIT)) begin
      acc_r <= literal_in;
    end else if (exec && op_in == OP_IND_LOAD) begin
      acc_r <= mem_rdata_in;
    end else if (exec && to_dest && !dest_in) begin
      acc_r <= result;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || state_r == ST_RESET) begin
      carry_r <= 1'b0;
      zero_r  <= 1'b0;
    end else if (exec) begin
      if (wr_carry) begin
        carry_r <= res_carry;
      end
      if (wr_zero) begin
        zero_r <= (result == 8'h00);
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || state_r == ST_RESET) begin
      ptr_r[0] <= `PTR_RESET;
      ptr_r[1] <= `PTR_RESET;
    end else if (exec && !rel_offset_in &&
                 (op_in == OP_IND_LOAD || op_in == OP_IND_STORE)) begin
      ptr_r[ptr_sel_in] <= ptr_upd;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || state_r == ST_RESET) begin
      bank_select_reg_out <= '0;
      pc_upper_latch_out  <= '0;
      prescaler_cfg_out   <= 8'hff;
    end else if (exec) begin
      if (op_in == OP_BANK_LIT) begin
        bank_select_reg_out <= {1'b0, literal_in[3:0]};
      end
      if (op_in == OP_PAGE_LIT) begin
        pc_upper_latch_out <= literal_in[6:0];
      end
      if (op_in == OP_PRESCALE) begin
        prescaler_cfg_out <= acc_r;
      end
    end
  end

  // Global enable survives only its own set; the software reset clears it
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || state_r == ST_RESET) begin
      irq_control_reg_out <= 8'h00;
    end else if (pop_gie_r && state_r == ST_POP) begin
      irq_control_reg_out[`GIE_BIT] <= 1'b1;
    end
  end

  // Active-low flag: cleared by the instruction, set by a pin reset
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ri_flag_r <= 1'b1;
    end else if (exec && op_in == OP_SW_RESET) begin
      ri_flag_r <= 1'b0;
    end
  end

  // ==========================================================
  // Output stage
  // ==========================================================
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      file_addr_out  <= 7'h00;
      file_we_out    <= 1'b0;
      file_wdata_out <= 8'h00;
      mem_addr_out   <= '0;
      mem_we_out     <= 1'b0;
      mem_wdata_out  <= 8'h00;
    end else begin
      file_addr_out  <= file_addr_in;
      file_we_out    <= exec && !alias_hit &&
                        ((to_dest && dest_in) || op_in == OP_ACC_STORE);
      file_wdata_out <= (op_in == OP_ACC_STORE) ? acc_r : result;
      mem_addr_out   <= (alias_hit && op_in != OP_IND_LOAD &&
                         op_in != OP_IND_STORE) ?
                        ptr_r[alias_sel] : ind_addr;
      mem_we_out     <= exec && (op_in == OP_IND_STORE ||
                        (alias_hit && ((to_dest && dest_in) ||
                                       op_in == OP_ACC_STORE)));
      mem_wdata_out  <= (op_in == OP_ACC_STORE || op_in == OP_IND_STORE) ?
                        acc_r : result;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      accumulator_out       <= 8'h00;
      status_out            <= 8'h00;
      power_control_reg_out <= 8'h00;
      indirect_pointer0_out <= `PTR_RESET;
      indirect_pointer1_out <= `PTR_RESET;
      busy_out              <= 1'b0;
      device_reset_out      <= 1'b0;
    end else begin
      accumulator_out       <= acc_r;
      status_out            <= {5'h00, zero_r, 1'b0, carry_r};
      power_control_reg_out <= {5'h00, ri_flag_r, 2'h0};
      indirect_pointer0_out <= ptr_r[0];
      indirect_pointer1_out <= ptr_r[1];
      busy_out              <= (state_nxt != ST_EXEC);
      device_reset_out      <= (state_nxt == ST_RESET);
    end
  end
endmodule
`default_nettype wire

/* File: hw/return_stack.sv */
// Circular hardware return stack
`timescale 1ns/1ps
`default_nettype none
`include "isa_exec_map.svh"
module return_stack #(
  parameter int DEPTH = `STACK_DEPTH,
  parameter int PC_W  = `PC_W
) (
  input  wire logic  ref_clk_in,
  input  wire logic  rst_in,
  stack_if.store     stk
);
  localparam int AW = $clog2(DEPTH);
  logic [PC_W-1:0] mem [DEPTH];
  logic [AW-1:0]   sp_r;

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be power of 2");
  end

  // Pointer wraps like the real stack; overflow is not trapped here
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      sp_r <= '0;
    end else if (stk.push) begin
      sp_r <= sp_r + AW'(1);
    end else if (stk.pop) begin
      sp_r <= sp_r - AW'(1);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (stk.push) begin
      mem[sp_r] <= stk.push_data;
    end
  end

  assign stk.top = mem[sp_r - AW'(1)];
endmodule
`default_nettype wire

/* File: hw/stack_if.sv */
// Push and pop carrier between the executor and its return stack
`timescale 1ns/1ps
`default_nettype none
interface stack_if #(parameter int PC_W = 15);
  logic            push;
  logic            pop;
  logic [PC_W-1:0] push_data;
  logic [PC_W-1:0] top;
  modport owner (output push, output pop, output push_data, input top);
  modport store (input push, input pop, input push_data, output top);
endinterface
`default_nettype wire
